// ### design/uart_aux_channel.sv
// one uart channel: soft flow control, sleep, loopback, dma, infrared
//
// Contract
// RULE1: 16-deep: pause at trigger 1/4/8/14, resume at 0/1/4/8, irq at trigger
// RULE2: 64-deep: pause at trigger 8/16/56/60, resume at 0/8/16/56, irq at trigger; the 32-entry fifo never reaches 56/60
// RULE3: special detect on: match second pause char, store it, flag special
// RULE4: compare characters at programmed length 5..8, lsb at bit 0
// RULE5: sleep only if enabled, no irq, divisor nonzero, no modem change, rx high
// RULE6: wake on rx falling edge, transmit write, or modem input change
// RULE7: re-sleep only after irqs clear; modem status read clears changes
// RULE8: loopback routes transmit shifter output into receive shifter
// RULE9: loopback: output mark, rts/dtr off, modem inputs ignored, auto flow off
// RULE10: outside keeps receive input high during loopback
// RULE11: status: tx buffer empty, shifter empty, rx data ready
// RULE12: single dma mode: each request stands for one character
// RULE13: block mode: rx request at trigger, drops only when rx empty
// RULE14: 16-deep block mode: tx request at empty, drop at full
// RULE15: 64-deep block mode: tx request when space exceeds threshold
// RULE16: dma keeps writing while tx request stands, stops at full
// RULE17: infrared mode: serial output idles low
// RULE18: infrared: 3/16-bit high pulse for each zero bit
// RULE19: infrared: each received pulse (active low) decodes as zero
// RULE20: driver waits four characters before shutting transmitter down
// RULE21: pause chars stop tx after frame, resume char restarts; not stored
// RULE22: auto send pause pair at upper trigger, resume pair at lower
// RULE23: infrared off: plain framing idling high, rx sampled undecoded
`timescale 1ns/1ps
`include "uart_aux_consts.svh"
module uart_aux_channel (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick16,
  input  wire logic        deep_variant,
  input  wire logic [1:0]  rx_trigger_sel,
  input  wire logic [1:0]  tx_threshold_sel,
  input  wire logic        dma_block_mode,
  input  wire logic        sw_flow_en,
  input  wire logic        special_detect_en,
  input  wire logic [1:0]  char_len_sel,
  input  wire logic        loopback_en,
  input  wire logic        infrared_en,
  input  wire logic        sleep_en,
  input  wire logic        irq_pending,
  input  wire logic        divisor_nonzero,
  input  wire logic [7:0]  first_pause_char,
  input  wire logic [7:0]  second_pause_char,
  input  wire logic [7:0]  first_resume_char,
  input  wire logic [7:0]  second_resume_char,
  input  wire logic [7:0]  rts_dtr_req,
  input  wire logic [3:0]  modem_in,
  input  wire logic        modem_status_read,
  input  wire logic        tx_wr,
  input  wire logic [7:0]  tx_wdata,
  output logic             tx_wr_ready,
  input  wire logic        rx_rd,
  output logic [7:0]       rx_rdata,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        serial_in_pin,
  output logic             rx_line,
  output logic             serial_out_pin,
  output logic [1:0]       rts_dtr_out,
  output logic             auto_flow_allowed,
  output logic [3:0]       modem_change,
  output logic             asleep,
  output logic             rx_dma_request,
  output logic             tx_dma_request,
  output logic             rx_trigger_irq,
  output logic             special_char_flag,
  output logic             tx_paused,
  output logic [2:0]       line_status
);
  typedef struct packed {
    uart_aux_pkg::tx_state_e tx_st;
    uart_aux_pkg::ctl_src_e  ctl;
    logic [3:0]  tick;
    logic [3:0]  bitn;
    logic [9:0]  shift;
    logic        ctl_second;
    logic        pause_sent;
    logic        paused;
    logic        got_first;
    logic        special;
    logic        rx_dma;
    logic        tx_dma;
    logic        asleep;
    logic        wake_hold;
    logic [3:0]  mchg;
    logic [3:0]  m_prev;
    logic [1:0]  rx_s;
    logic [7:0]  m_s;
    logic        rx_prev;
    logic        out;
  } chan_s;
  chan_s st_reg;
  chan_s st_next;

  logic [7:0]  rx_masked;
  logic        rx_store;
  logic [7:0]  fifo_in;
  logic        tx_out_valid;
  logic [7:0]  tx_out_data;
  logic        tx_pop;
  logic [5:0]  tx_cnt;
  logic        rx_in_ready;
  logic        rx_out_valid;
  logic [5:0]  rx_cnt;
  logic [6:0]  trig;
  logic [6:0]  resume_lvl;
  logic [6:0]  tx_space;
  logic [6:0]  tx_thresh;
  logic        rx_clean;
  logic [3:0]  modem_eff;

  function automatic logic [7:0] len_mask(input logic [1:0] sel);
    len_mask = 8'hff >> (2'd3 - sel);
  endfunction

  function automatic logic char_eq(input logic [7:0] a, input logic [7:0] b,
                                   input logic [1:0] sel);
    char_eq = ((a ^ b) & len_mask(sel)) == 8'h00;
  endfunction

  // rx capacity is the local fifo; deep variant thresholds still compared
  sync_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_LOG2)) rx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (fifo_in),
    .in_valid  (rx_store),
    .in_ready  (rx_in_ready),
    .out_data  (rx_rdata),
    .out_valid (rx_out_valid),
    .out_ready (rx_rd),
    .count     (rx_cnt)
  );

  sync_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_LOG2)) tx_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (tx_wdata),
    .in_valid  (tx_wr),
    .in_ready  (tx_wr_ready),
    .out_data  (tx_out_data),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .count     (tx_cnt)
  );

  assign rx_masked = rx_char & len_mask(char_len_sel); // RULE4
  // flow characters are dropped, special characters kept as data
  assign rx_store  = rx_char_valid && !(sw_flow_en &&
                     (char_eq(rx_char, first_pause_char, char_len_sel) ||
                      char_eq(rx_char, second_pause_char, char_len_sel) ||
                      char_eq(rx_char, first_resume_char, char_len_sel) ||
                      char_eq(rx_char, second_resume_char, char_len_sel)))
                     || (rx_char_valid && special_detect_en &&
                     char_eq(rx_char, second_pause_char, char_len_sel)); // RULE21
  assign fifo_in   = rx_masked;

  always_comb
  begin
    // RULE1 RULE2
    if (deep_variant)
    begin
      case (rx_trigger_sel)
        2'd0:    begin trig = 7'd8;  resume_lvl = 7'd0;  end
        2'd1:    begin trig = 7'd16; resume_lvl = 7'd8;  end
        2'd2:    begin trig = 7'd56; resume_lvl = 7'd16; end
        default: begin trig = 7'd60; resume_lvl = 7'd56; end
      endcase
    end
    else
    begin
      case (rx_trigger_sel)
        2'd0:    begin trig = 7'd1;  resume_lvl = 7'd0; end
        2'd1:    begin trig = 7'd4;  resume_lvl = 7'd1; end
        2'd2:    begin trig = 7'd8;  resume_lvl = 7'd4; end
        default: begin trig = 7'd14; resume_lvl = 7'd8; end
      endcase
    end
  end

  // space counted against the physical buffer, not the variant's depth
  assign tx_space  = 7'(`FIFO_DEPTH) - 7'(tx_cnt);
  assign tx_thresh = {1'b0, tx_threshold_sel, 4'h0} >> (deep_variant ? 0 : 1);
  // active-low pulse already reads as a zero, so no inversion in either mode
  assign rx_clean  = st_reg.rx_s[1]; // RULE19 RULE23
  assign rx_line   = loopback_en ? st_reg.out : rx_clean; // RULE8
  assign modem_eff = loopback_en ? 4'h0 : st_reg.m_s[7:4]; // RULE9
  assign tx_pop    = (st_reg.tx_st == uart_aux_pkg::TX_IDLE) && tick16 &&
                     tx_out_valid && !st_reg.paused &&
                     (st_reg.ctl == uart_aux_pkg::SRC_NONE) && !st_reg.asleep;

  always_comb
  begin
    st_next = st_reg;
    st_next.rx_s = {st_reg.rx_s[0], serial_in_pin};
    st_next.m_s  = {st_reg.m_s[3:0], modem_in};
    st_next.rx_prev = rx_clean;
    st_next.m_prev  = modem_eff;
    // modem change set wins over a same-cycle status read
    st_next.mchg = (modem_status_read ? 4'h0 : st_reg.mchg) |
                   (modem_eff ^ st_reg.m_prev); // RULE7
    // flow control receive side
    if (rx_char_valid && sw_flow_en)
    begin
      if (char_eq(rx_char, first_pause_char, char_len_sel))
        st_next.got_first = 1'b1;
      else if (st_reg.got_first &&
               char_eq(rx_char, second_pause_char, char_len_sel))
        st_next.paused = 1'b1; // RULE21
      else
        st_next.got_first = 1'b0;
      if (char_eq(rx_char, first_resume_char, char_len_sel) ||
          char_eq(rx_char, second_resume_char, char_len_sel))
        st_next.paused = 1'b0; // RULE21
    end
    if (rx_char_valid && special_detect_en &&
        char_eq(rx_char, second_pause_char, char_len_sel))
      st_next.special = 1'b1; // RULE3
    else if (rx_rd && rx_cnt == 6'd1)
      st_next.special = 1'b0;
    // auto pause / resume queueing
    if (sw_flow_en && st_reg.ctl == uart_aux_pkg::SRC_NONE)
    begin
      if (!st_reg.pause_sent && 7'(rx_cnt) >= trig)
      begin
        st_next.ctl = uart_aux_pkg::SRC_PAUSE; // RULE22
        st_next.pause_sent = 1'b1;
      end
      else if (st_reg.pause_sent && 7'(rx_cnt) <= resume_lvl)
      begin
        st_next.ctl = uart_aux_pkg::SRC_RESUME; // RULE22
        st_next.pause_sent = 1'b0;
      end
    end
    // dma requests
    if (dma_block_mode)
    begin
      if (7'(rx_cnt) >= trig)
        st_next.rx_dma = 1'b1; // RULE13
      else if (rx_cnt == 6'd0)
        st_next.rx_dma = 1'b0;
      if ((deep_variant && tx_space > tx_thresh) || tx_cnt == 6'd0)
        st_next.tx_dma = 1'b1; // RULE14 RULE15
      else if (!tx_wr_ready)
        st_next.tx_dma = 1'b0; // RULE16
    end
    else
    begin
      st_next.rx_dma = rx_out_valid && !rx_rd; // RULE12
      st_next.tx_dma = (tx_cnt == 6'd0) && !tx_wr; // RULE12
    end
    // sleep
    if (st_reg.asleep)
    begin
      if ((st_reg.rx_prev && !rx_clean) || tx_wr || (st_reg.mchg != 4'h0) ||
          !sleep_en)
      begin
        st_next.asleep = 1'b0; // RULE6
        st_next.wake_hold = sleep_en;
      end
    end
    else if (st_reg.wake_hold)
    begin
      if (irq_pending)
        st_next.wake_hold = 1'b0; // RULE7
      else if (!sleep_en)
        st_next.wake_hold = 1'b0;
    end
    else if (sleep_en && !irq_pending && divisor_nonzero &&
             st_reg.mchg == 4'h0 && rx_clean &&
             st_reg.tx_st == uart_aux_pkg::TX_IDLE && !tx_out_valid)
      st_next.asleep = 1'b1; // RULE5
    // transmitter, one bit per 16 ticks
    if (tick16)
    begin
      case (st_reg.tx_st)
        uart_aux_pkg::TX_IDLE:
        begin
          st_next.out = 1'b1;
          if (st_reg.ctl != uart_aux_pkg::SRC_NONE)
          begin
            st_next.shift = {1'b1, st_reg.ctl == uart_aux_pkg::SRC_PAUSE ?
              (st_reg.ctl_second ? second_pause_char : first_pause_char) :
              (st_reg.ctl_second ? second_resume_char : first_resume_char),
              1'b0} & {1'b1, len_mask(char_len_sel), 1'b1}; // RULE22
            if (st_reg.ctl_second)
              st_next.ctl = uart_aux_pkg::SRC_NONE;
            st_next.ctl_second = !st_reg.ctl_second;
            st_next.tx_st = uart_aux_pkg::TX_SHIFT;
          end
          else if (tx_pop)
          begin
            st_next.shift = {1'b1, tx_out_data & len_mask(char_len_sel), 1'b0};
            st_next.tx_st = uart_aux_pkg::TX_SHIFT;
          end
          st_next.tick = 4'h0;
          st_next.bitn = 4'h0;
        end
        uart_aux_pkg::TX_SHIFT:
        begin
          st_next.out  = st_reg.shift[0];
          st_next.tick = st_reg.tick + 4'h1;
          if (st_reg.tick == `BIT_TICKS)
          begin
            st_next.shift = {1'b1, st_reg.shift[9:1]};
            st_next.bitn  = st_reg.bitn + 4'h1;
            if (st_reg.bitn == 4'd5 + 4'(char_len_sel))
              st_next.tx_st = uart_aux_pkg::TX_STOP;
          end
        end
        uart_aux_pkg::TX_STOP:
        begin
          st_next.out  = 1'b1;
          st_next.tick = st_reg.tick + 4'h1;
          if (st_reg.tick == `BIT_TICKS)
            st_next.tx_st = uart_aux_pkg::TX_IDLE; // RULE21
        end
        default: st_next.tx_st = uart_aux_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.tx_st <= uart_aux_pkg::TX_IDLE;
      st_reg.ctl   <= uart_aux_pkg::SRC_NONE;
      st_reg.out   <= 1'b1;
      st_reg.rx_s  <= 2'b11;
    end
    else
      st_reg <= st_next;
  end

  // output pin: infrared pulse in the first 3 ticks of each zero bit
  always_comb
  begin
    if (loopback_en)
      serial_out_pin = !infrared_en; // RULE9
    else if (infrared_en)
      // a bit shows on out from tick 1 on, so pulse in ticks 1..3
      serial_out_pin = !st_reg.out &&
                       ((st_reg.tick - 4'h1) < `IR_PULSE_TICKS); // RULE17 RULE18
    else
      serial_out_pin = st_reg.out; // RULE23
  end

  assign rts_dtr_out       = loopback_en ? 2'b00 : rts_dtr_req[1:0]; // RULE9
  assign auto_flow_allowed = !loopback_en; // RULE9
  assign modem_change      = st_reg.mchg;
  assign asleep            = st_reg.asleep;
  assign rx_dma_request    = st_reg.rx_dma;
  assign tx_dma_request    = st_reg.tx_dma;
  assign rx_trigger_irq    = 7'(rx_cnt) >= trig; // RULE1 RULE2
  assign special_char_flag = st_reg.special;
  assign tx_paused         = st_reg.paused;
  assign line_status = {st_reg.tx_st == uart_aux_pkg::TX_IDLE && !tx_out_valid,
                        !tx_out_valid, rx_out_valid}; // RULE11

  AST_SLEEP_GATE: assert property (@(posedge clk) disable iff (rst)
    $rose(st_reg.asleep) |-> $past(sleep_en) && $past(!irq_pending)) // RULE5
    else $error("sleep entered without conditions");
  AST_WAKE_TX: assert property (@(posedge clk) disable iff (rst)
    st_reg.asleep && tx_wr |=> !st_reg.asleep) // RULE6
    else $error("write did not wake channel");
  AST_LOOP_MARK: assert property (@(posedge clk) disable iff (rst)
    loopback_en && !infrared_en |-> serial_out_pin && rts_dtr_out == 2'b00) // RULE9
    else $error("loopback output not mark");
  AST_LOOP_PATH: assert property (@(posedge clk) disable iff (rst)
    loopback_en |-> rx_line == st_reg.out) // RULE8
    else $error("loopback path broken");
  AST_IR_IDLE: assert property (@(posedge clk) disable iff (rst)
    infrared_en && !loopback_en && st_reg.out |-> !serial_out_pin) // RULE17
    else $error("infrared output not idle low");
  AST_RX_DMA_HOLD: assert property (@(posedge clk) disable iff (rst)
    dma_block_mode && $past(dma_block_mode) && $fell(st_reg.rx_dma)
    |-> $past(rx_cnt) == 6'd0) // RULE13
    else $error("rx request dropped while data left");
  AST_TX_DMA_FULL: assert property (@(posedge clk) disable iff (rst)
    dma_block_mode && $past(dma_block_mode) && $fell(st_reg.tx_dma)
    |-> $past(!tx_wr_ready)) // RULE14
    else $error("tx request dropped before full");
  AST_STATUS: assert property (@(posedge clk) disable iff (rst)
    line_status[0] == (rx_cnt != 6'd0)) // RULE11
    else $error("rx ready status wrong");
endmodule

// ### shared/uart_aux_consts.svh
// constants for the uart auxiliary channel logic
`ifndef UART_AUX_CONSTS_SVH
`define UART_AUX_CONSTS_SVH
`define DATA_W         8
`define FIFO_DEPTH     32
`define CNT_W          7
`define SMALL_DEPTH    7'd16
`define LARGE_DEPTH    7'd64
`define BIT_TICKS      4'd15
`define IR_PULSE_TICKS 4'd3
`define FRAME_BITS     4'd10
`define FIFO_LOG2      5
`endif

// ### shared/uart_aux_pkg.sv
// types for the uart auxiliary channel logic
package uart_aux_pkg;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_SHIFT = 4'b0010,
    TX_STOP  = 4'b0100,
    TX_GAP   = 4'b1000
  } tx_state_e;
  typedef enum logic [2:0] {
    SRC_NONE  = 3'b001,
    SRC_PAUSE = 3'b010,
    SRC_RESUME = 3'b100
  } ctl_src_e;
endpackage

// ### design/sync_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [AW:0]           count
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_s;
  fifo_s st_reg;
  fifo_s st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;
  assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = mem[st_reg.rp];
  assign count     = st_reg.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb
  begin
    st_next = st_reg;
    if (push)
      st_next.wp = st_reg.wp + 1'b1;
    if (pop)
      st_next.rp = st_reg.rp + 1'b1;
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
    if (push)
      mem[st_reg.wp] <= in_data;
  end
endmodule

// ### tb/remote_side.sv
// remote transceiver model: bit tick source and serial frame decoder
`timescale 1ns/1ps
module remote_side (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   run,
  input  wire logic   ir,
  input  wire logic   line,
  output logic        tick16,
  output logic        got,
  output logic [7:0]  got_byte,
  output logic [15:0] ir_pulses,
  output logic [15:0] ir_high
);
  logic       busy;
  logic       prev;
  logic [7:0] tc;
  logic [7:0] sh;
  initial
  begin
    {tick16, got, busy, prev, got_byte, tc, sh} = '0;
    {ir_pulses, ir_high} = '0;
  end
  always @(posedge clk)
  begin
    got <= 1'b0;
    // tick every other cycle; stands still while run is low, before the tx test raises it
    tick16 <= run && !tick16;
    prev <= line;
    if (ir && line && !prev) ir_pulses <= ir_pulses + 16'h1;
    if (ir && line) ir_high <= ir_high + 16'h1;
    if (rst)
      busy <= 1'b0;
    else if (tick16 && !busy && !ir && !line)
    begin
      busy <= 1'b1;
      tc <= 8'd1;
    end
    else if (tick16 && busy)
    begin
      tc <= tc + 8'd1;
      // mid-bit sampling, lsb first, eight data bits
      if (tc[3:0] == 4'h8 && tc > 8'd8 && tc < 8'd140) sh <= {line, sh[7:1]};
      if (tc == 8'd152)
      begin
        busy <= 1'b0;
        got <= 1'b1;
        got_byte <= sh;
      end
    end
  end
endmodule

// ### tb/testbench.sv
// bench: drives the channel, models its fifos and serial traffic
`timescale 1ns/1ps
module testbench;
  logic        clk, rst, deep_variant, dma_block_mode, sw_flow_en, run;
  logic        special_detect_en, loopback_en, infrared_en, sleep_en;
  logic        irq_pending, divisor_nonzero, modem_status_read, tx_wr;
  logic        rx_rd, rx_char_valid, serial_in_pin, tx_wr_ready, rx_line;
  logic        serial_out_pin, auto_flow_allowed, asleep, tx_paused;
  logic        rx_dma_request, tx_dma_request, rx_trigger_irq;
  logic        special_char_flag, tick16, got;
  logic [1:0]  rx_trigger_sel, tx_threshold_sel, char_len_sel, rts_dtr_out;
  logic [2:0]  line_status;
  logic [3:0]  modem_in, modem_change;
  logic [7:0]  rts_dtr_req, tx_wdata, rx_rdata, rx_char, got_byte, b;
  logic [7:0]  first_pause_char, second_pause_char;
  logic [7:0]  first_resume_char, second_resume_char;
  logic [15:0] ir_pulses, ir_high, ps, hs;
  logic [7:0]  txq[$];
  logic [7:0]  rxq[$];
  integer      seed, bad_count, samples_checked, i, j, n, nrx, snap;
  int          trig[6] = '{1, 4, 8, 14, 8, 16};
  uart_aux_channel uart_aux_channel_inst (.*);
  remote_side remote_side_inst (.clk(clk), .rst(rst), .run(run),
    .ir(infrared_en), .line(serial_out_pin), .tick16(tick16), .got(got),
    .got_byte(got_byte), .ir_pulses(ir_pulses), .ir_high(ir_high));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (got) nrx <= nrx + 1;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] d, input bit keep);
    tx_wr <= 1'b1;
    tx_wdata <= d;
    if (keep) txq.push_back(d);
    @(posedge clk);
  endtask
  task automatic rxp(input logic [7:0] d, input bit keep);
    rx_char_valid <= 1'b1;
    rx_char <= d;
    if (keep) rxq.push_back(d);
    @(posedge clk);
  endtask
  task automatic rd(input bit cmp);
    logic [7:0] e;
    e = rxq.pop_front();
    rx_rd <= 1'b1;
    #1;
    if (cmp) check(rx_rdata, e);
    @(posedge clk);
  endtask
  task automatic getb();
    n = 0;
    while (!got && n < 4000)
    begin
      @(posedge clk);
      n = n + 1;
    end
    check(got_byte, txq.pop_front());
    @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #150000;
    bad_count = bad_count + 1;
    report_and_stop();
  end
  initial
  begin
    {seed, bad_count, samples_checked, nrx} = {32'd20357, 96'd0};
    {deep_variant, dma_block_mode, sw_flow_en, special_detect_en} = '0;
    {loopback_en, infrared_en, sleep_en, irq_pending, run} = '0;
    {modem_status_read, tx_wr, rx_rd, rx_char_valid} = '0;
    {rx_trigger_sel, tx_threshold_sel, modem_in, tx_wdata, rx_char} = '0;
    {divisor_nonzero, serial_in_pin, rst, char_len_sel} = 5'h1f;
    rts_dtr_req = 8'h03;
    {first_pause_char, second_pause_char} = 16'h1317;
    {first_resume_char, second_resume_char} = 16'h1112;
    cyc(3);
    rst <= 1'b0;
    cyc(2);
    check(serial_out_pin, 1'b1);
    check(line_status, 3'b110);
    check({rx_dma_request, tx_dma_request, asleep}, 3'b010);
    $display("done: reset");
    // fill the tx fifo while the bit tick stands still
    dma_block_mode <= 1'b1;
    for (i = 0; i < 32; i++) wr(8'($random(seed)), 1);
    wr(8'hee, 0);
    tx_wr <= 1'b0;
    cyc(2);
    check({tx_wr_ready, tx_dma_request}, 2'b00);
    check(line_status, 3'b000);
    {deep_variant, tx_threshold_sel} <= 3'b101;
    run <= 1'b1;
    for (i = 0; i < 16; i++) getb();
    check(tx_dma_request, 1'b0);
    getb();
    cyc(1);
    check(tx_dma_request, 1'b1);
    for (i = 0; i < 15; i++) getb();
    cyc(40);
    check(line_status, 3'b110);
    $display("done: tx fifo and dma");
    dma_block_mode <= 1'b0;
    rxp(8'h5a, 1);
    rx_char_valid <= 1'b0;
    cyc(2);
    check({rx_dma_request, line_status[0]}, 2'b11);
    rd(1);
    rx_rd <= 1'b0;
    cyc(2);
    check(rx_dma_request, 1'b0);
    dma_block_mode <= 1'b1;
    // 64-deep levels above 32 cannot be reached with these fifos
    for (j = 0; j < 6; j++)
    begin
      deep_variant <= (j > 3);
      rx_trigger_sel <= 2'(j % 4);
      for (i = 1; i < trig[j]; i++) rxp(8'($random(seed)), 1);
      rx_char_valid <= 1'b0;
      cyc(2);
      check({rx_trigger_irq, rx_dma_request}, 2'b00);
      rxp(8'($random(seed)), 1);
      rx_char_valid <= 1'b0;
      cyc(2);
      check({rx_trigger_irq, rx_dma_request}, 2'b11);
      while (rxq.size() > 1) rd(1);
      rx_rd <= 1'b0;
      cyc(2);
      check(rx_dma_request, 1'b1);
      rd(1);
      rx_rd <= 1'b0;
      cyc(2);
      check(rx_dma_request, 1'b0);
    end
    $display("done: rx triggers");
    {deep_variant, rx_trigger_sel, sw_flow_en} <= 4'b0011;
    for (i = 0; i < 4; i++) rxp(8'($random(seed)) | 8'h80, 1);
    rx_char_valid <= 1'b0;
    txq.push_back(first_pause_char);
    txq.push_back(second_pause_char);
    getb();
    getb();
    for (i = 0; i < 3; i++) rd(1);
    rx_rd <= 1'b0;
    txq.push_back(first_resume_char);
    txq.push_back(second_resume_char);
    getb();
    getb();
    rd(1);
    rx_rd <= 1'b0;
    rxp(first_pause_char, 0);
    rxp(second_pause_char, 0);
    rx_char_valid <= 1'b0;
    cyc(3);
    check({tx_paused, line_status[0]}, 2'b10);
    snap = nrx;
    wr(8'h3c, 1);
    tx_wr <= 1'b0;
    cyc(400);
    check(16'(nrx), 16'(snap));
    rxp(first_resume_char, 0);
    rx_char_valid <= 1'b0;
    getb();
    check(tx_paused, 1'b0);
    $display("done: soft flow");
    {sw_flow_en, special_detect_en, char_len_sel} <= 4'b0100;
    rxp(8'h14, 1);
    rx_char_valid <= 1'b0;
    cyc(2);
    check(special_char_flag, 1'b0);
    rxp(8'hf7, 1);
    rx_char_valid <= 1'b0;
    cyc(2);
    check({special_char_flag, line_status[0]}, 2'b11);
    rd(0);
    rd(0);
    rx_rd <= 1'b0;
    cyc(2);
    check(special_char_flag, 1'b0);
    {special_detect_en, char_len_sel} <= 3'b011;
    $display("done: special char");
    check(rts_dtr_out, 2'b11);
    loopback_en <= 1'b1;
    modem_in <= 4'h5;
    cyc(5);
    check({serial_out_pin, rts_dtr_out, auto_flow_allowed}, 4'b1000);
    check(modem_change, 4'h0);
    modem_in <= 4'h0;
    wr(8'h00, 0);
    tx_wr <= 1'b0;
    n = 0;
    while (rx_line && n < 400)
    begin
      @(posedge clk);
      n = n + 1;
    end
    check({rx_line, serial_out_pin}, 2'b01);
    // serial_in_pin held high all through loopback
    cyc(400);
    loopback_en <= 1'b0;
    $display("done: loopback");
    infrared_en <= 1'b1;
    cyc(2);
    check(serial_out_pin, 1'b0);
    {ps, hs} = {ir_pulses, ir_high};
    b = 8'($random(seed));
    wr(b, 0);
    tx_wr <= 1'b0;
    cyc(400);
    check(ir_pulses - ps, 16'(9 - $countones(b)));
    check(ir_high - hs, 16'(6 * (9 - $countones(b))));
    serial_in_pin <= 1'b0;
    cyc(4);
    check(rx_line, 1'b0);
    serial_in_pin <= 1'b1;
    cyc(40);
    check(rx_line, 1'b1);
    infrared_en <= 1'b0;
    $display("done: infrared");
    {sleep_en, irq_pending} <= 2'b11;
    cyc(5);
    check(asleep, 1'b0);
    irq_pending <= 1'b0;
    cyc(4);
    check(asleep, 1'b1);
    {modem_in, irq_pending} <= 5'h05;
    cyc(5);
    check(asleep, 1'b0);
    modem_status_read <= 1'b1;
    cyc(1);
    modem_status_read <= 1'b0;
    cyc(4);
    check({modem_change, asleep}, 5'h00);
    irq_pending <= 1'b0;
    cyc(4);
    check(asleep, 1'b1);
    irq_pending <= 1'b1;
    wr(8'h96, 1);
    tx_wr <= 1'b0;
    cyc(2);
    check(asleep, 1'b0);
    {sleep_en, irq_pending} <= 2'b00;
    cyc(4);
    check(asleep, 1'b0);
    getb();
    $display("done: sleep");
    // drain time of four characters before the run closes
    cyc(4 * 320);
    report_and_stop();
  end
endmodule
